// *** src/ricc_pkg.sv ***
// Package for the remote input and cycle control block: constants and types
package ricc_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int DEBOUNCE_US = 5000;
  // Least settle time, exact in whole cycles at this rate
  localparam int DB_CYCLES = DEBOUNCE_US * (CLK_HZ / 1_000_000);
  localparam int DB_W = 17;

  // ----------------------------------------------------------------------
  // Contact closure input channels
  // ----------------------------------------------------------------------
  localparam int IN_START = 0;
  localparam int IN_ESTOP = 1;
  localparam int IN_HDIS = 2;
  localparam int IN_VDIS = 3;
  localparam int IN_NULL = 4;
  localparam int IN_CUTOFF = 5;
  localparam int N_IN = 6;

  // ----------------------------------------------------------------------
  // Feature configuration word, switch position n sits at bit n-1
  // ----------------------------------------------------------------------
  localparam int CFG_TACK = 0;
  localparam int CFG_AUTO = 1;
  localparam int CFG_ZSRCH = 2;
  localparam int CFG_STNULL = 3;
  localparam int CFG_VDELAY = 4;
  localparam int CFG_HDELAY = 5;
  localparam int CFG_LOCK = 6;
  localparam int CFG_CRATER = 7;
  localparam logic [7:0] CFG_RST = 8'h00;

  // ----------------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_SW = 8'h08;
  localparam logic [7:0] REG_PROG = 8'h0c;

  typedef enum logic [2:0] {
    S_IDLE, S_SEARCH, S_NULL_HOLD, S_WELD, S_OVERLAP, S_FINAL, S_RETRACT
  } ricc_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } ricc_bus_req_t;

  // Same-clock status from the rest of the tracker and the pendant
  typedef struct packed {
    logic auto_mode_sel;
    logic side_left_sel;
    logic side_right_sel;
    logic seam_located;
    logic tack_detected;
    logic weld_timer_done;
    logic updown_seen;
    logic overlap_done;
    logic final_done;
    logic retract_done;
  } ricc_trk_t;

  typedef struct packed {
    logic weld_go_relay;
    logic final_phase_relay;
    logic retract_phase_relay;
    logic manual_mode;
    logic tracking_mode;
    logic overlap_mode;
    logic horiz_track_en;
    logic vert_track_en;
    logic sidetrack_left;
    logic sidetrack_right;
    logic anti_jam_en;
    logic tack_cutoff_armed;
    logic weld_timer_run;
  } ricc_out_t;

  typedef struct packed {
    logic [N_IN-1:0] sync1;
    logic [N_IN-1:0] sync2;
    logic [N_IN-1:0] db;
    logic [N_IN-1:0] db_d;
    logic [N_IN-1:0][DB_W-1:0] cnt;
    logic [7:0] sw1;
    logic [7:0] sw2;
    logic [7:0] cfg;
    logic wto;
    ricc_state_t state;
    ricc_out_t out;
    logic [DATA_W-1:0] rdata;
  } ricc_st_t;

endpackage

// *** src/ricc_remote_ctrl.sv ***
// Remote input handling and weld cycle control of the seam tracker
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/100ps

// Behaviour
// - Emergency stop aborts cycle, drops all three relays, selects manual mode
// - No new cycle starts while emergency stop is held
// - Horizontal disable suspends horizontal tracking while held
// - Horizontal disable overrides the sidetrack selection
// - Held null sync keeps weld timer stopped and weld-go relay off
// - Shared null sync line holds weld phase until last unit finds seam
// - Null sync release at null energises weld-go and starts weld at once
// - Cutoff pulse ends weld phase anywhere and forces overlap mode
// - Vertical disable suspends vertical tracking while held
// - Axis disables act in every phase, not only while welding
// - Either axis disable suppresses anti-jam protection
// - Detected tack switches both slides into manual mode
// - Feature bit 1 enables tack cutoff
// - Feature bit 2 selects auto cutoff, else timed weld
// - Bit 3 enables Z search; bit 4 disables sidetrack at null
// - Feature bit 5 enables the vertical search delay
// - Feature bit 6 enables the horizontal retract delay
// - Bit 8 enables crater fill delay; bit 7 enables lockout
// - Weld-go relay on from weld phase entry (seam located or null release) until final timer ends
// - Start only in auto mode; held start restarts after retract
module ricc_remote_ctrl
  import ricc_pkg::*;
#(
  parameter int DB_CNT = DB_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Remote contact closure pins, high while closed
  input wire logic start_input_pin,
  input wire logic estop_input_pin,
  input wire logic horiz_disable_pin,
  input wire logic vert_disable_pin,
  input wire logic null_sync_pin,
  input wire logic cutoff_input_pin,
  input wire logic [7:0] feature_config_switch,
  // Tracker and pendant status
  input wire ricc_trk_t trk,
  // Register port
  input wire ricc_bus_req_t bus,
  output logic [DATA_W-1:0] bus_rdata,
  // Relays, modes and features
  output ricc_out_t ctl,
  output logic [7:0] feature_cfg
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  ricc_st_t st_r;
  ricc_st_t st_nxt;
  logic [N_IN-1:0] pins;
  logic estop;
  logic start_rise;
  logic cutoff_rise;
  logic null_reached;
  logic side_ok;

  assign pins = {cutoff_input_pin, null_sync_pin, vert_disable_pin,
                 horiz_disable_pin, estop_input_pin, start_input_pin};

  // Edges are taken from the debounced copies only
  assign estop = st_r.db[IN_ESTOP];
  assign start_rise = st_r.db[IN_START] & ~st_r.db_d[IN_START];
  assign cutoff_rise = st_r.db[IN_CUTOFF] & ~st_r.db_d[IN_CUTOFF];

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    null_reached = 1'b0;
    side_ok = 1'b0;

    // synchronise and debounce
    // The settle counter restarts on any bounce, so a chattering contact
    // never reaches the cycle logic. Counts above 2^17 do not fit.
    st_nxt.sync1 = pins;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.db_d = st_r.db;
    for (int i = 0; i < N_IN; i++) begin
      if (st_r.sync2[i] == st_r.db[i]) begin
        st_nxt.cnt[i] = '0;
      end else if (st_r.cnt[i] == DB_W'(DB_CNT - 1)) begin
        st_nxt.db[i] = st_r.sync2[i];
        st_nxt.cnt[i] = '0;
      end else begin
        st_nxt.cnt[i] = st_r.cnt[i] + 1'b1;
      end
    end

    // Feature switches only need a clean level, not a debounce
    st_nxt.sw1 = feature_config_switch;
    st_nxt.sw2 = st_r.sw1;

    // Cycle sequencing
    unique case (st_r.state)
      S_IDLE: begin
        if (start_rise && trk.auto_mode_sel) begin
          st_nxt.state = S_SEARCH;
        end
      end
      S_SEARCH: begin
        if (trk.seam_located) begin
          st_nxt.state = st_r.db[IN_NULL] ? S_NULL_HOLD : S_WELD;
        end
      end
      S_NULL_HOLD: begin
        // the shared line releases only after the last unit nulls
        if (!st_r.db[IN_NULL]) begin
          st_nxt.state = S_WELD;
        end
      end
      S_WELD: begin
        if (trk.weld_timer_done && st_r.cfg[CFG_AUTO]) begin
          st_nxt.wto = 1'b1;
        end
        if (cutoff_rise) begin
          st_nxt.state = S_OVERLAP;
        end else if (!st_r.cfg[CFG_AUTO] && trk.weld_timer_done) begin
          st_nxt.state = S_OVERLAP;
        end else if (st_r.cfg[CFG_AUTO] && st_r.wto && trk.updown_seen) begin
          st_nxt.state = S_OVERLAP;
        end
      end
      S_OVERLAP: begin
        if (trk.overlap_done) begin
          st_nxt.state = S_FINAL;
        end
      end
      S_FINAL: begin
        if (trk.final_done) begin
          st_nxt.state = S_RETRACT;
        end
      end
      S_RETRACT: begin
        if (trk.retract_done) begin
          if (st_r.db[IN_START] && trk.auto_mode_sel) begin
            st_nxt.state = S_SEARCH;
          end else begin
            st_nxt.state = S_IDLE;
          end
        end
      end
      // The eighth code is never entered; recover to idle if upset
      default: begin
        st_nxt.state = S_IDLE;
      end
    endcase

    if (st_nxt.state != S_WELD) begin
      st_nxt.wto = 1'b0;
    end

    if (estop) begin
      st_nxt.state = S_IDLE;
      st_nxt.wto = 1'b0;
    end

    // Outputs follow the next state so that they sit in flip-flops
    // weld-go span
    st_nxt.out.weld_go_relay = st_nxt.state inside {S_WELD, S_OVERLAP,
                                                   S_FINAL};
    st_nxt.out.final_phase_relay = (st_nxt.state == S_FINAL);
    st_nxt.out.retract_phase_relay = (st_nxt.state == S_RETRACT);
    st_nxt.out.weld_timer_run = (st_nxt.state == S_WELD);
    st_nxt.out.overlap_mode = (st_nxt.state == S_OVERLAP);
    st_nxt.out.tracking_mode = st_nxt.state inside {S_SEARCH, S_NULL_HOLD,
                                                   S_WELD};
    st_nxt.out.tack_cutoff_armed = st_r.cfg[CFG_TACK] &&
                                   (st_nxt.state == S_WELD);
    st_nxt.out.manual_mode = (st_nxt.state == S_IDLE) ||
                             (st_nxt.out.tack_cutoff_armed &&
                              trk.tack_detected);
    st_nxt.out.horiz_track_en = st_nxt.out.tracking_mode &&
                                !st_nxt.out.manual_mode &&
                                !st_r.db[IN_HDIS];
    st_nxt.out.vert_track_en = st_nxt.out.tracking_mode &&
                               !st_nxt.out.manual_mode &&
                               !st_r.db[IN_VDIS];
    st_nxt.out.anti_jam_en = st_nxt.out.tracking_mode &&
                             !st_r.db[IN_HDIS] && !st_r.db[IN_VDIS];
    null_reached = st_nxt.state inside {S_NULL_HOLD, S_WELD};
    side_ok = !st_r.db[IN_HDIS] &&
              !(st_r.cfg[CFG_STNULL] && null_reached);
    st_nxt.out.sidetrack_left = side_ok && trk.side_left_sel;
    st_nxt.out.sidetrack_right = side_ok && trk.side_right_sel;

    // Register writes; the stored word feeds every feature decision
    // stored feature word
    if (bus.wr && bus.addr == REG_CFG) begin
      st_nxt.cfg = bus.wdata[7:0];
    end
    if (bus.wr && bus.addr == REG_PROG && bus.wdata[0]) begin
      st_nxt.cfg = st_r.sw2;
    end

    // Read data stands only in the cycle after the strobe
    st_nxt.rdata = '0;
    if (bus.rd) begin
      unique case (bus.addr)
        REG_CFG: st_nxt.rdata = {24'h000000, st_r.cfg};
        REG_STAT: st_nxt.rdata = {16'h0000, st_r.state, st_r.out};
        REG_SW: st_nxt.rdata = {24'h000000, st_r.sw2};
        default: st_nxt.rdata = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Ports straight from the state flip-flops
  assign ctl = st_r.out;
  assign bus_rdata = st_r.rdata;
  assign feature_cfg = st_r.cfg;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  a_estop_relays_off: assert property (
    estop |=> !ctl.weld_go_relay && !ctl.final_phase_relay &&
              !ctl.retract_phase_relay && ctl.manual_mode)
    else $error("relays not dropped on emergency stop");

  a_estop_no_start: assert property (
    st_r.state == S_IDLE && estop |=> st_r.state == S_IDLE)
    else $error("cycle began while emergency stop held");

  a_hdis_stops_h: assert property (
    st_r.db[IN_HDIS] |=> !ctl.horiz_track_en)
    else $error("horizontal tracking while disabled");

  a_hdis_sidetrack: assert property (
    st_r.db[IN_HDIS] |=> !ctl.sidetrack_left && !ctl.sidetrack_right)
    else $error("sidetrack active under horizontal disable");

  a_null_hold_off: assert property (
    st_r.state == S_NULL_HOLD && st_r.db[IN_NULL]
      |=> !ctl.weld_go_relay && !ctl.weld_timer_run)
    else $error("weld started while null sync held");

  a_null_release_go: assert property (
    st_r.state == S_NULL_HOLD && !st_r.db[IN_NULL] && !estop
      |=> ctl.weld_go_relay && ctl.weld_timer_run)
    else $error("weld did not start on null release");

  a_cutoff_overlap: assert property (
    st_r.state == S_WELD && cutoff_rise && !estop
      |=> ctl.overlap_mode ##0 st_r.state == S_OVERLAP)
    else $error("cutoff did not force overlap");

  a_vdis_stops_v: assert property (
    st_r.db[IN_VDIS] |=> !ctl.vert_track_en)
    else $error("vertical tracking while disabled");

  a_antijam_off: assert property (
    (st_r.db[IN_HDIS] || st_r.db[IN_VDIS]) |=> !ctl.anti_jam_en)
    else $error("anti-jam active under axis disable");

  a_tack_manual: assert property (
    st_nxt.state == S_WELD && st_r.cfg[CFG_TACK] && trk.tack_detected
      |=> ctl.manual_mode && !ctl.horiz_track_en && !ctl.vert_track_en)
    else $error("tack did not select manual mode");

  a_weld_go_span: assert property (
    st_r.state == S_FINAL && trk.final_done && !estop
      |=> !ctl.weld_go_relay && ctl.retract_phase_relay)
    else $error("weld-go relay outlived final phase");

  // Only the channels that moved must match their settled input
  a_debounce_hold: assert property (
    $changed(st_r.db) |->
      ((st_r.db ^ $past(st_r.sync2)) & (st_r.db ^ $past(st_r.db))) == '0)
    else $error("debounced level changed without settled input");

  // Start, feature and shared null checks
  a_start_auto_only: assert property (
    st_r.state == S_IDLE && !trk.auto_mode_sel |=> st_r.state == S_IDLE)
    else $error("cycle began outside auto mode");

  a_shared_null_hold: assert property (
    st_r.state == S_SEARCH && trk.seam_located && st_r.db[IN_NULL] &&
      !estop |=> st_r.state == S_NULL_HOLD && !ctl.weld_go_relay)
    else $error("weld phase began while shared null line held");

  a_tack_unarmed: assert property (
    !st_r.cfg[CFG_TACK] |=> !ctl.tack_cutoff_armed)
    else $error("tack cutoff armed with feature off");

  a_auto_weld_hold: assert property (
    st_r.state == S_WELD && st_r.cfg[CFG_AUTO] && !st_r.wto &&
      !cutoff_rise && !estop |=> st_r.state == S_WELD)
    else $error("auto cutoff ended weld before timer ran out");

  // Sidetrack at null follows the stored feature word
  a_stnull_side: assert property (
    st_r.cfg[CFG_STNULL] && st_nxt.state inside {S_NULL_HOLD, S_WELD}
      |=> !ctl.sidetrack_left && !ctl.sidetrack_right)
    else $error("sidetrack active at null with feature on");

  c_full_cycle: cover property (
    st_r.state == S_RETRACT ##1 st_r.state == S_IDLE);
  c_null_wait: cover property (
    st_r.state == S_NULL_HOLD ##1 st_r.state == S_WELD);
  c_cutoff: cover property (st_r.state == S_WELD && cutoff_rise);
  c_restart: cover property (
    st_r.state == S_RETRACT ##1 st_r.state == S_SEARCH);
  c_tack: cover property (ctl.tack_cutoff_armed && trk.tack_detected);

endmodule

// *** tb/ricc_switch_model.sv ***
// Model of the remote contacts: operator switches, PLC or shared lines
`timescale 1ns/100ps
module ricc_switch_model (
  // Clock
  input wire logic ref_clk,
  // Requested contact levels, chatter on change
  input wire logic [5:0] want,
  input wire logic bounce_en,
  // Contact lines, high while closed
  output logic [5:0] pins
);
  logic [5:0] old_r = 6'h00;
  logic [5:0] tgt_r = 6'h00;
  logic [2:0] n_r = 3'h7;
  initial pins = 6'h00;
  // Contacts settle after chatter
  // Each chatter lasts one cycle, so a block that acted on raw
  // levels would trigger repeatedly
  always @(posedge ref_clk) begin
    if (want != tgt_r) begin
      old_r <= tgt_r;
      tgt_r <= want;
      n_r <= 3'h0;
    end else if (n_r != 3'h7) begin
      n_r <= n_r + 3'h1;
    end
    pins <= (bounce_en && n_r < 3'h5 && !n_r[0]) ? old_r : tgt_r;
  end
endmodule

// *** tb/ricc_remote_ctrl_bench.sv ***
// Self-checking bench of the remote input and cycle control block
`timescale 1ns/100ps
module ricc_remote_ctrl_bench;
  import ricc_pkg::*;
  // --------------------------------------------------------------
  // Signals, instances and tasks
  // --------------------------------------------------------------
  localparam int DBN = 4;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [5:0] want = 6'h00;
  logic bounce_en = 1'b1;
  logic [5:0] pins;
  logic [7:0] sw = 8'h00;
  ricc_trk_t trk = '0;
  ricc_bus_req_t bus = '0;
  logic [DATA_W-1:0] bus_rdata;
  ricc_out_t ctl;
  logic [7:0] feature_cfg;
  logic [31:0] d;
  int miscompares = 0;
  int n_tests = 0;

  // Half period of the 20 MHz clock
  always #25 ref_clk = ~ref_clk;

  ricc_switch_model sw_u (.ref_clk(ref_clk), .want(want),
    .bounce_en(bounce_en), .pins(pins));

  ricc_remote_ctrl #(.DB_CNT(DBN)) dut_u (.ref_clk(ref_clk), .nrst(nrst),
    .start_input_pin(pins[IN_START]), .estop_input_pin(pins[IN_ESTOP]),
    .horiz_disable_pin(pins[IN_HDIS]), .vert_disable_pin(pins[IN_VDIS]),
    .null_sync_pin(pins[IN_NULL]), .cutoff_input_pin(pins[IN_CUTOFF]),
    .feature_config_switch(sw), .trk(trk), .bus(bus),
    .bus_rdata(bus_rdata), .ctl(ctl), .feature_cfg(feature_cfg));

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    bus.addr <= a;
    bus.wdata <= v;
    bus.wr <= 1'b1;
    @(posedge ref_clk);
    bus.wr <= 1'b0;
    #1;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1 d = bus_rdata;
  endtask

  task automatic state_is(input ricc_state_t s);
    rd(REG_STAT);
    chk("state", {29'h0, s}, {29'h0, d[15:13]});
  endtask

  // Long enough for chatter, two sync stages and the settle count
  task automatic pin(input int ch, input logic v);
    @(posedge ref_clk);
    want[ch] <= v;
    repeat (DBN + 14) @(posedge ref_clk);
    #1;
  endtask

  // One-cycle status pulse from the tracker, bit index of trk
  task automatic ev(input int b);
    @(posedge ref_clk);
    trk[b] <= 1'b1;
    @(posedge ref_clk);
    trk[b] <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    end_sim;
  end

  // --------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------
  initial begin
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    trk.auto_mode_sel <= 1'b1;
    trk.side_left_sel <= 1'b1;
    rd(REG_CFG);
    chk("cfg reset", {24'h0, CFG_RST}, d);
    rd(8'h10);
    chk("unmapped", 32'h0, d);
    for (int i = 0; i < 8; i++) begin
      wr(REG_CFG, 32'h1 << i);
      chk("cfg", 32'h1 << i, {24'h0, feature_cfg});
    end
    // Program store copies the switch positions
    @(posedge ref_clk);
    sw <= 8'ha5;
    repeat (3) @(posedge ref_clk);
    rd(REG_SW);
    chk("switches", 32'ha5, d);
    wr(REG_PROG, 32'h1);
    chk("program", 32'ha5, {24'h0, feature_cfg});
    wr(REG_CFG, 32'h0);
    // Start is ignored outside auto mode
    @(posedge ref_clk);
    trk.auto_mode_sel <= 1'b0;
    pin(IN_START, 1'b1);
    state_is(S_IDLE);
    pin(IN_START, 1'b0);
    @(posedge ref_clk);
    trk.auto_mode_sel <= 1'b1;
    // Timed cycle with null sync held, start left closed
    pin(IN_NULL, 1'b1);
    pin(IN_START, 1'b1);
    state_is(S_SEARCH);
    chk("tracking", 32'h1, {31'h0, ctl.tracking_mode});
    ev(6);
    state_is(S_NULL_HOLD);
    chk("weld_go", 32'h0, {31'h0, ctl.weld_go_relay});
    chk("timer", 32'h0, {31'h0, ctl.weld_timer_run});
    pin(IN_NULL, 1'b0);
    state_is(S_WELD);
    chk("weld_go", 32'h1, {31'h0, ctl.weld_go_relay});
    chk("timer", 32'h1, {31'h0, ctl.weld_timer_run});
    // Axis disables at null
    pin(IN_HDIS, 1'b1);
    chk("htrack", 32'h0, {31'h0, ctl.horiz_track_en});
    chk("side", 32'h0, {30'h0, ctl.sidetrack_left,
      ctl.sidetrack_right});
    chk("antijam", 32'h0, {31'h0, ctl.anti_jam_en});
    pin(IN_HDIS, 1'b0);
    chk("htrack", 32'h1, {31'h0, ctl.horiz_track_en});
    chk("side", 32'h2, {30'h0, ctl.sidetrack_left,
      ctl.sidetrack_right});
    // Sidetrack dropped at null once the feature is on
    wr(REG_CFG, 32'h8);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("side", 32'h0, {30'h0, ctl.sidetrack_left,
      ctl.sidetrack_right});
    wr(REG_CFG, 32'h0);
    pin(IN_VDIS, 1'b1);
    chk("vtrack", 32'h0, {31'h0, ctl.vert_track_en});
    chk("antijam", 32'h0, {31'h0, ctl.anti_jam_en});
    pin(IN_VDIS, 1'b0);
    chk("vtrack", 32'h1, {31'h0, ctl.vert_track_en});
    chk("antijam", 32'h1, {31'h0, ctl.anti_jam_en});
    pin(IN_CUTOFF, 1'b1);
    state_is(S_OVERLAP);
    chk("overlap", 32'h1, {31'h0, ctl.overlap_mode});
    pin(IN_CUTOFF, 1'b0);
    ev(2);
    chk("final", 32'h1, {31'h0, ctl.final_phase_relay});
    chk("weld_go", 32'h1, {31'h0, ctl.weld_go_relay});
    ev(1);
    chk("retract", 32'h1, {31'h0, ctl.retract_phase_relay});
    chk("weld_go", 32'h0, {31'h0, ctl.weld_go_relay});
    ev(0);
    state_is(S_SEARCH);
    // Auto cutoff with tack cutoff, then emergency stop in final
    wr(REG_CFG, 32'h3);
    ev(6);
    state_is(S_WELD);
    chk("armed", 32'h1, {31'h0, ctl.tack_cutoff_armed});
    // Manual mode stands only while the tack is seen, so hold it
    @(posedge ref_clk);
    trk.tack_detected <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("manual", 32'h1, {31'h0, ctl.manual_mode});
    chk("htrack", 32'h0, {31'h0, ctl.horiz_track_en});
    @(posedge ref_clk);
    trk.tack_detected <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("manual", 32'h0, {31'h0, ctl.manual_mode});
    // Up/down before the timer ran out must not end the weld
    ev(3);
    state_is(S_WELD);
    ev(4);
    state_is(S_WELD);
    ev(3);
    state_is(S_OVERLAP);
    ev(2);
    pin(IN_ESTOP, 1'b1);
    state_is(S_IDLE);
    chk("relays", 32'h0, {29'h0, ctl.weld_go_relay,
      ctl.final_phase_relay, ctl.retract_phase_relay});
    chk("manual", 32'h1, {31'h0, ctl.manual_mode});
    pin(IN_START, 1'b0);
    pin(IN_START, 1'b1);
    state_is(S_IDLE);
    pin(IN_START, 1'b0);
    pin(IN_ESTOP, 1'b0);
    pin(IN_START, 1'b1);
    state_is(S_SEARCH);
    end_sim;
  end
endmodule
